// >>> hw/mcfu_core.sv
// microcore control, housekeeping and flow instruction unit
module mcfu_core #(
	parameter int NHS = 5,
	parameter int NLS = 6
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// instruction slot
	input  wire logic        instr_valid,
	input  wire logic [4:0]  instr_op,
	input  wire logic [15:0] instr_arg,
	output logic             instr_ready,
	output logic [9:0]       program_counter,
	output logic             in_irq,
	output logic             start_latch_clr,
	// data RAM
	input  wire logic [15:0] alu_index,
	input  wire logic [9:0]  ram_offset,
	input  wire logic        ram_rd_en,
	input  wire logic [15:0] ram_rdata,
	output logic [9:0]       ram_addr,
	output logic [15:0]      ram_rd_value,
	// flags and core registers
	output logic [15:0]      flag_bus,
	output logic [15:0]      core_control,
	output logic [15:0]      core_status,
	output logic [15:0]      diagnosis_error,
	output logic             alu_saturate,
	// channel exchange
	input  wire logic [63:0] peer_exchange,
	output logic [15:0]      channel_exchange_register,
	output logic [15:0]      peer_read_value,
	// register backdoor
	input  wire logic        bd_locked,
	input  wire logic [15:0] bd_rdata,
	output logic [8:0]       bd_addr,
	output logic [15:0]      bd_data,
	output logic             bd_wr,
	output logic             bd_rd,
	output logic             host_interrupt_pin,
	// diagnosis
	input  wire logic [NHS-1:0] hs_vds_fbk,
	input  wire logic [NHS-1:0] hs_src_fbk,
	input  wire logic [NHS-1:0] hs_cmd,
	input  wire logic [NLS-1:0] ls_vds_fbk,
	input  wire logic [NLS-1:0] ls_cmd,
	input  wire logic [15:0] highside_diagnosis_combination,
	input  wire logic [15:0] lowside_diagnosis_combination,
	input  wire logic [15:0] output_access_grant,
	input  wire logic [9:0]  diagnosis_routine_address,
	input  wire logic [9:0]  core_entry_point,
	input  wire logic [9:0]  irq_vector,
	// driver supervision
	input  wire logic [15:0] driver_configuration,
	input  wire logic        drivers_enabled,
	input  wire logic [15:0] driver_state
);
	localparam int ND = NHS + NLS;
	// one bit of a word replaced
	function automatic logic [15:0] put_bit(input logic [15:0] w,
		input logic [3:0] idx, input logic val);
		logic [15:0] r;
		r = w;
		r[idx] = val;
		return r;
	endfunction
	// decoded slot
	wire                  accept = instr_valid & instr_ready;
	wire mcfu_pkg::mcfu_op_t op  = mcfu_pkg::mcfu_op_t'(instr_op);
	wire logic [3:0]      a_idx  = instr_arg[mcfu_pkg::ARG_BIT_IDX +: 4];
	wire                  a_val  = instr_arg[mcfu_pkg::ARG_BIT_VAL];
	wire logic            is_op[32];
	generate
		// driver counts that the enables and grants can hold
		if (NHS < 1 || NLS < 1 || NHS + NLS > 16) begin : g_chk
			$error("driver counts out of range");
		end
		for (genvar k = 0; k < 32; k++) begin : g_dec
			assign is_op[k] = accept & (op == mcfu_pkg::mcfu_op_t'(k));
		end
	endgenerate
	// state registers
	mcfu_pkg::mcfu_bd_t   bd_state;   // backdoor sequencer
	mcfu_pkg::mcfu_ret_t  ret_mode;   // auto return behaviour
	logic                 rd_mask;    // reads masked
	logic                 rd_swap;    // reads byte-swapped
	logic                 base_sel;   // 1: index register base
	logic [9:0]           add_base;   // data RAM base
	logic [1:0]           chan_sel;   // peer being accessed
	logic                 bd_is_rd;   // current backdoor kind
	logic [ND-1:0]        diag_en;    // monitor enables
	logic [ND-1:0]        shortcut;   // pre-driver shortcuts
	logic [ND-1:0]        diag_hit;   // matched drivers
	logic [9:0]           aux;        // subroutine return
	logic                 sub_active; // inside a subroutine
	logic [9:0]           iret_pc;    // interrupt return
	logic [2:0]           pend;       // diag, driver, software
	logic                 en_prev;    // drivers_enabled delayed
	logic                 ds_prev;    // driver state busy delayed
	wire logic [ND-1:0] active = diag_en & output_access_grant[ND-1:0];
	mcfu_diag #(.NHS(NHS), .NLS(NLS)) u_diag (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.hs_vds_fbk (hs_vds_fbk),
		.hs_src_fbk (hs_src_fbk),
		.hs_cmd     (hs_cmd),
		.ls_vds_fbk (ls_vds_fbk),
		.ls_cmd     (ls_cmd),
		.hs_comb    (highside_diagnosis_combination),
		.ls_comb    (lowside_diagnosis_combination),
		.active     (active),
		.hit        (diag_hit)
	);
	// interrupt events and selection
	wire       ds_busy  = |driver_state;
	wire       rc_bit   = driver_configuration[mcfu_pkg::DRVCFG_RET_BIT];
	wire logic [2:0] ev = {is_op[mcfu_pkg::OP_REQI], ds_busy & ~ds_prev, |diag_hit};
	wire logic [2:0] want = pend | ev;
	wire       take     = ~in_irq & |want;
	wire logic [2:0] grant = want[0] ? 3'h1 : (want[1] ? 3'h2 : 3'h4);
	wire       ret_cond = rc_bit ? (ds_prev & ~ds_busy) : (drivers_enabled & ~en_prev);
	wire       auto_ret = in_irq & ret_cond & (ret_mode != mcfu_pkg::RET_IGNORE);
	wire       do_iret  = in_irq & is_op[mcfu_pkg::OP_IRET];
	wire       leave    = auto_ret | do_iret;
	wire       q_clr    = do_iret & instr_arg[mcfu_pkg::ARG_IRET_RST];
	// sequential pc after the slot
	wire logic [9:0] pc_inc = program_counter + 10'h001;
	logic [9:0] seq_pc;
	always_comb begin
		seq_pc = program_counter;
		if (accept) begin
			seq_pc = pc_inc;
			if (op == mcfu_pkg::OP_CALL && !sub_active) seq_pc = instr_arg[9:0];
			if (op == mcfu_pkg::OP_RFS && sub_active) seq_pc = aux + 10'h001;
		end
	end
	// pc selection: entry, return, sequence
	logic [9:0] next_pc;
	always_comb begin
		next_pc = seq_pc;
		if (take) begin
			next_pc = grant[0] ? diagnosis_routine_address : irq_vector;
		end else if (leave) begin
			next_pc = (ret_mode == mcfu_pkg::RET_RESTART) ? core_entry_point : iret_pc;
		end
	end
	// indexed address base
	wire logic [9:0] next_ram_addr = (base_sel ? alu_index[9:0] : add_base) + ram_offset;
	// read shaping
	wire logic [15:0] shaped = rd_mask ? mcfu_pkg::RST_WORD :
		(rd_swap ? {ram_rdata[7:0], ram_rdata[15:8]} : ram_rdata);
	wire logic [15:0] peer_pick = peer_exchange[{chan_sel, 4'h0} +: 16];
	// backdoor sequencer next state
	wire bd_go = is_op[mcfu_pkg::OP_WRSPI] | is_op[mcfu_pkg::OP_RDSPI];
	mcfu_pkg::mcfu_bd_t next_bd;
	always_comb begin
		case (bd_state)
			mcfu_pkg::BD_IDLE: next_bd = bd_go ? mcfu_pkg::BD_XFER : mcfu_pkg::BD_IDLE;
			mcfu_pkg::BD_XFER: next_bd = mcfu_pkg::BD_IDLE;
			default:           next_bd = mcfu_pkg::BD_IDLE;
		endcase
	end
	// flow state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			program_counter <= mcfu_pkg::RST_PC;
			aux             <= mcfu_pkg::RST_PC;
			sub_active      <= 1'b0;
			iret_pc         <= mcfu_pkg::RST_PC;
			in_irq          <= 1'b0;
			pend            <= 3'h0;
			en_prev         <= 1'b1; // idle level: drivers enabled, no false rise
			ds_prev         <= 1'b0;
		end else begin
			program_counter <= next_pc;
			en_prev         <= drivers_enabled;
			ds_prev         <= ds_busy;
			if (is_op[mcfu_pkg::OP_CALL] && !sub_active) begin
				aux        <= program_counter;
				sub_active <= 1'b1;
			end else if (is_op[mcfu_pkg::OP_RFS]) begin
				sub_active <= 1'b0;
			end
			if (take) iret_pc <= seq_pc;
			if (take) in_irq <= 1'b1;
			else if (leave) in_irq <= 1'b0;
			// queue: new events win over clearing
			pend <= ((q_clr ? 3'h0 : pend) | ev) & ~(take ? grant : 3'h0);
		end
	end
	// data RAM and flag state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_mask      <= 1'b0;
			rd_swap      <= 1'b0;
			base_sel     <= 1'b0;
			add_base     <= mcfu_pkg::RST_PC;
			ram_addr     <= mcfu_pkg::RST_PC;
			ram_rd_value <= mcfu_pkg::RST_WORD;
			flag_bus     <= mcfu_pkg::RST_WORD;
		end else begin
			if (is_op[mcfu_pkg::OP_STDRM]) begin
				rd_mask <= instr_arg[mcfu_pkg::ARG_RD_MASK];
				rd_swap <= instr_arg[mcfu_pkg::ARG_RD_SWAP];
			end
			if (ram_rd_en) ram_rd_value <= shaped;
			if (is_op[mcfu_pkg::OP_SLAB]) base_sel <= a_val;
			if (is_op[mcfu_pkg::OP_STAB]) add_base <= instr_arg[9:0];
			ram_addr <= next_ram_addr;
			if (is_op[mcfu_pkg::OP_STF]) flag_bus <= put_bit(flag_bus, a_idx, a_val);
		end
	end
	// core registers, diagnosis errors, configuration
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			core_control    <= mcfu_pkg::RST_WORD;
			core_status     <= mcfu_pkg::RST_WORD;
			diagnosis_error <= mcfu_pkg::RST_WORD;
			alu_saturate    <= 1'b0;
			start_latch_clr <= 1'b0;
			ret_mode        <= mcfu_pkg::RET_RESUME;
			host_interrupt_pin <= 1'b0;
		end else begin
			start_latch_clr <= is_op[mcfu_pkg::OP_RSTSL];
			if (is_op[mcfu_pkg::OP_RSTREG] && instr_arg[mcfu_pkg::ARG_RST_CTRL])
				core_control <= mcfu_pkg::RST_WORD;
			else if (is_op[mcfu_pkg::OP_STCRB])
				core_control <= put_bit(core_control, a_idx, a_val);
			if (is_op[mcfu_pkg::OP_RSTREG] && instr_arg[mcfu_pkg::ARG_RST_STAT])
				core_status <= mcfu_pkg::RST_WORD;
			else if (is_op[mcfu_pkg::OP_STSRB])
				core_status <= put_bit(core_status, a_idx, a_val);
			// errors: new hits win over reset
			diagnosis_error <= ((is_op[mcfu_pkg::OP_RSTREG] &&
				instr_arg[mcfu_pkg::ARG_RST_ERR]) ? mcfu_pkg::RST_WORD : diagnosis_error)
				| 16'(diag_hit);
			if (is_op[mcfu_pkg::OP_STAL]) alu_saturate <= a_val;
			if (is_op[mcfu_pkg::OP_ICONF]) ret_mode <= mcfu_pkg::mcfu_ret_t'(instr_arg[1:0]);
			if (is_op[mcfu_pkg::OP_PIN_DRIVE]) host_interrupt_pin <= a_val;
		end
	end
	// channel exchange and diagnosis enables
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			channel_exchange_register <= mcfu_pkg::RST_WORD;
			peer_read_value <= mcfu_pkg::RST_WORD;
			chan_sel        <= 2'h0;
			diag_en         <= '0;
			shortcut        <= '0;
		end else begin
			if (is_op[mcfu_pkg::OP_LDRX]) channel_exchange_register <= instr_arg;
			if (is_op[mcfu_pkg::OP_STCRT]) chan_sel <= instr_arg[1:0];
			peer_read_value <= peer_pick;
			if (is_op[mcfu_pkg::OP_DFSCT]) shortcut <= instr_arg[ND-1:0];
			if (is_op[mcfu_pkg::OP_ENDIAG]) diag_en[a_idx] <= a_val;
			else if (is_op[mcfu_pkg::OP_ENDIAGA]) diag_en <= {ND{a_val}};
			else if (is_op[mcfu_pkg::OP_ENDIAGS])
				diag_en <= a_val ? (diag_en | shortcut) : (diag_en & ~shortcut);
		end
	end
	// backdoor transfer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bd_state    <= mcfu_pkg::BD_IDLE;
			bd_is_rd    <= 1'b0;
			bd_addr     <= 9'h000;
			bd_data     <= mcfu_pkg::RST_WORD;
			bd_wr       <= 1'b0;
			bd_rd       <= 1'b0;
			instr_ready <= 1'b1;
		end else begin
			bd_state    <= next_bd;
			instr_ready <= next_bd == mcfu_pkg::BD_IDLE;
			if (is_op[mcfu_pkg::OP_SLSA]) bd_addr <= instr_arg[8:0];
			if (bd_go) bd_is_rd <= is_op[mcfu_pkg::OP_RDSPI];
			bd_wr <= is_op[mcfu_pkg::OP_WRSPI] & ~bd_locked;
			bd_rd <= is_op[mcfu_pkg::OP_RDSPI] & ~bd_locked;
			if (is_op[mcfu_pkg::OP_LDSD]) bd_data <= instr_arg;
			else if (bd_state == mcfu_pkg::BD_XFER && bd_is_rd && bd_rd) bd_data <= bd_rdata;
		end
	end
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence bd_issue_s;
		is_op[mcfu_pkg::OP_WRSPI] && !bd_locked;
	endsequence
	sequence bd_busy_s;
		!instr_ready ##1 instr_ready;
	endsequence
	bd_two_a: assert property (bd_issue_s |=> bd_wr and bd_busy_s)
		else $error("backdoor write not two cycles");
	bd_lock_a: assert property (bd_locked && bd_go |=> !bd_wr && !bd_rd)
		else $error("locked backdoor access issued");
	rstsl_a: assert property ($rose(start_latch_clr) |-> $past(is_op[mcfu_pkg::OP_RSTSL]))
		else $error("start latch clear without instruction");
	stab_load_a: assert property (is_op[mcfu_pkg::OP_STAB]
		|=> add_base == $past(instr_arg[9:0]))
		else $error("base not loaded");
	stf_bit_a: assert property (is_op[mcfu_pkg::OP_STF]
		|=> flag_bus[$past(a_idx)] == $past(a_val))
		else $error("flag bit not driven");
	sat_cfg_a: assert property (is_op[mcfu_pkg::OP_STAL] |=> alu_saturate == $past(a_val))
		else $error("saturation not set");
	pin_drv_a: assert property (is_op[mcfu_pkg::OP_PIN_DRIVE]
		|=> host_interrupt_pin == $past(a_val))
		else $error("interrupt pin not forced");
	call_save_a: assert property (is_op[mcfu_pkg::OP_CALL] && !sub_active && !take
		|=> aux == $past(program_counter) && program_counter == $past(instr_arg[9:0]))
		else $error("call did not save pc");
	rfs_ret_a: assert property (is_op[mcfu_pkg::OP_RFS] && sub_active && !take && !leave
		|=> program_counter == $past(aux) + 10'h001 && !sub_active)
		else $error("subroutine return wrong");
	diag_prio_a: assert property (take && want[0]
		|=> in_irq && program_counter == $past(diagnosis_routine_address))
		else $error("diagnosis not first");
	one_level_a: assert property (in_irq && !leave |=> in_irq)
		else $error("interrupt left without return");
endmodule

// >>> pkg/mcfu_pkg.sv
// shared constants and types of the microcore control flow unit
package mcfu_pkg;
	// register offsets as seen by the host
	localparam logic [8:0] OFS_CORE_CONTROL  = 9'h101;
	localparam logic [8:0] OFS_CORE_STATUS   = 9'h105;
	localparam logic [8:0] OFS_CORE0_ENTRY   = 9'h10A;
	localparam logic [8:0] OFS_CORE1_ENTRY   = 9'h10B;
	localparam logic [8:0] OFS_DIAG_ROUTINE  = 9'h10C;
	localparam logic [8:0] OFS_LS_DIAG_COMB  = 9'h141;
	localparam logic [8:0] OFS_HS_DIAG_COMB  = 9'h154;
	localparam logic [8:0] OFS_DIAG_ERROR    = 9'h162;
	localparam logic [8:0] OFS_OUT_ACCESS    = 9'h184;
	localparam logic [8:0] OFS_DRIVER_CONFIG = 9'h1C5;
	localparam logic [8:0] OFS_RESET_BEHAV   = 9'h1CE;
	localparam logic [8:0] OFS_DRIVER_STATE  = 9'h1D2;
	// operand fields
	localparam int ARG_BIT_IDX  = 0;  // 4-bit bit index
	localparam int ARG_BIT_VAL  = 4;  // level for bit ops
	localparam int ARG_RST_CTRL = 0;  // register reset group bits
	localparam int ARG_RST_STAT = 1;
	localparam int ARG_RST_ERR  = 2;
	localparam int ARG_RD_MASK  = 0;  // read mode bits
	localparam int ARG_RD_SWAP  = 1;
	localparam int ARG_IRET_RST = 1;  // clear queued interrupts
	localparam int DRVCFG_RET_BIT   = 0;  // return-condition bit
	localparam int RSTB_DRV_CLR_BIT = 0;  // driver_state_clear_on_read_bit
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [9:0]  RST_PC   = 10'h000;
	// instruction codes
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_RSTSL = 5'h01, OP_STDRM = 5'h02, OP_SLAB = 5'h03,
		OP_STAB = 5'h04, OP_STF = 5'h05, OP_RSTREG = 5'h06, OP_STCRB = 5'h07,
		OP_STSRB = 5'h08, OP_STAL = 5'h09, OP_STCRT = 5'h0A, OP_ICONF = 5'h0B,
		OP_SLSA = 5'h0C, OP_WRSPI = 5'h0D, OP_RDSPI = 5'h0E, OP_PIN_DRIVE = 5'h0F,
		OP_ENDIAG = 5'h10, OP_ENDIAGA = 5'h11, OP_ENDIAGS = 5'h12, OP_DFSCT = 5'h13,
		OP_CALL = 5'h14, OP_RFS = 5'h15, OP_REQI = 5'h16, OP_IRET = 5'h17,
		OP_LDSD = 5'h18, OP_LDRX = 5'h19
	} mcfu_op_t;
	// automatic return behaviour
	typedef enum logic [1:0] {
		RET_RESUME = 2'h0, RET_RESTART = 2'h1, RET_IGNORE = 2'h3
	} mcfu_ret_t;
	// backdoor sequencer
	typedef enum logic [1:0] {
		BD_IDLE = 2'h0, BD_XFER = 2'h1
	} mcfu_bd_t;
endpackage

// >>> hw/mcfu_diag.sv
// per-driver diagnosis pattern match
module mcfu_diag #(
	parameter int NHS = 5,
	parameter int NLS = 6
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	// driver feedback
	input  wire logic [NHS-1:0]       hs_vds_fbk,
	input  wire logic [NHS-1:0]       hs_src_fbk,
	input  wire logic [NHS-1:0]       hs_cmd,
	input  wire logic [NLS-1:0]       ls_vds_fbk,
	input  wire logic [NLS-1:0]       ls_cmd,
	// combination patterns: low bits value, next bits care
	input  wire logic [15:0]          hs_comb,
	input  wire logic [15:0]          ls_comb,
	// effective enables
	input  wire logic [NHS+NLS-1:0]   active,
	// matched drivers
	output logic      [NHS+NLS-1:0]   hit
);
	logic [NHS+NLS-1:0] next_hit; // combinational match
	generate
		if (NHS + NLS > 16) begin : g_chk
			$error("too many drivers");
		end
		// high side: vds, src, cmd
		for (genvar i = 0; i < NHS; i++) begin : g_hs
			assign next_hit[i] = active[i] &
				(({hs_vds_fbk[i], hs_src_fbk[i], hs_cmd[i]} ^ hs_comb[2:0])
				& hs_comb[5:3]) == 3'h0;
		end
		// low side: vds, cmd
		for (genvar j = 0; j < NLS; j++) begin : g_ls
			assign next_hit[NHS+j] = active[NHS+j] &
				(({ls_vds_fbk[j], ls_cmd[j]} ^ ls_comb[1:0]) & ls_comb[3:2]) == 2'h0;
		end
	endgenerate
	// registered match
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) hit <= '0;
		else hit <= next_hit;
	end
endmodule

// >>> tb/mcfu_host_model.sv
// register space behind the backdoor and the driver state word
module mcfu_host_model #(
	parameter logic [8:0] LOCK_ADDR = 9'h0FF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// backdoor requests from the core
	input  wire logic [8:0]  bd_addr,
	input  wire logic [15:0] bd_data,
	input  wire logic        bd_wr,
	input  wire logic        bd_rd,
	output logic             bd_locked,
	output logic [15:0]      bd_rdata,
	// driver faults raised by the bench
	input  wire logic [15:0] fault_in,
	output logic [15:0]      driver_state
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [512];  // plain register space
	wire logic   st_sel;     // driver state addressed
	wire logic   clr_rd;     // read that clears the state
	assign st_sel = (bd_addr == mcfu_pkg::OFS_DRIVER_STATE);
	assign clr_rd = bd_rd && st_sel && mem[mcfu_pkg::OFS_RESET_BEHAV][mcfu_pkg::RSTB_DRV_CLR_BIT];
	assign bd_locked = (bd_addr == LOCK_ADDR);
	assign bd_rdata = st_sel ? driver_state : mem[bd_addr];
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			driver_state <= 16'h0000;
		end else begin
			driver_state <= (clr_rd ? 16'h0000 : driver_state) | fault_in;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (bd_wr && !bd_locked) begin
			mem[bd_addr] <= bd_data;
		end
	end
endmodule

// >>> tb/testbench.sv
// self-checking bench of the control flow unit
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected at %0t: %h vs %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus
	logic        sys_clk, nrst, instr_valid, ram_rd_en, drivers_enabled;
	logic [4:0]  instr_op, hs_vds_fbk, hs_src_fbk, hs_cmd;
	logic [5:0]  ls_vds_fbk, ls_cmd;
	logic [15:0] instr_arg, alu_index, ram_rdata, output_access_grant, fault_in;
	logic [15:0] highside_diagnosis_combination, lowside_diagnosis_combination;
	logic [15:0] driver_configuration;
	logic [9:0]  ram_offset, diagnosis_routine_address, core_entry_point, irq_vector;
	logic [63:0] peer_exchange;
	// observed
	logic        instr_ready, in_irq, start_latch_clr, alu_saturate, bd_wr, bd_rd;
	logic        host_interrupt_pin, bd_locked;
	logic [9:0]  program_counter, ram_addr;
	logic [8:0]  bd_addr;
	logic [15:0] ram_rd_value, flag_bus, core_control, core_status, diagnosis_error;
	logic [15:0] channel_exchange_register, peer_read_value, bd_data, bd_rdata, driver_state;
	// bookkeeping
	int          err_total, comparisons, cycles;
	logic [9:0]  pc_exp, p0;
	mcfu_core mcfu_core_i (
		.sys_clk, .nrst, .instr_valid, .instr_op, .instr_arg, .instr_ready, .program_counter,
		.in_irq, .start_latch_clr, .alu_index, .ram_offset, .ram_rd_en, .ram_rdata, .ram_addr,
		.ram_rd_value, .flag_bus, .core_control, .core_status, .diagnosis_error, .alu_saturate,
		.peer_exchange, .channel_exchange_register, .peer_read_value, .bd_locked, .bd_rdata,
		.bd_addr, .bd_data, .bd_wr, .bd_rd, .host_interrupt_pin, .hs_vds_fbk, .hs_src_fbk,
		.hs_cmd, .ls_vds_fbk, .ls_cmd, .highside_diagnosis_combination,
		.lowside_diagnosis_combination, .output_access_grant, .diagnosis_routine_address,
		.core_entry_point, .irq_vector, .driver_configuration, .drivers_enabled, .driver_state
	);
	mcfu_host_model mcfu_host_model_i (
		.sys_clk, .nrst, .bd_addr, .bd_data, .bd_wr, .bd_rd, .bd_locked, .bd_rdata, .fault_in,
		.driver_state
	);
	// clock, 100 ns period
	always #50 sys_clk = ~sys_clk;
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			stop_test();
		end
	end
	// verdict and end of run
	task automatic stop_test();
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one instruction, settled outputs on return
	task automatic ex(mcfu_pkg::mcfu_op_t o, logic [15:0] a);
		@(posedge sys_clk);
		instr_valid <= 1'h1;
		instr_op <= o;
		instr_arg <= a;
		@(posedge sys_clk);
		instr_valid <= 1'h0;
		#1;
		pc_exp++;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// bit ops, group clears, pulses and levels
	task automatic t_bits();
		logic [15:0] e [3] = '{3{16'h0000}};
		mcfu_pkg::mcfu_op_t ops [3] = '{mcfu_pkg::OP_STF, mcfu_pkg::OP_STCRB, mcfu_pkg::OP_STSRB};
		logic [15:0] g;
		`CHK({flag_bus, core_control, core_status, diagnosis_error}, 64'h0) // reset
		for (int j = 0; j < 3; j++) begin
			for (int i = 0; i < 17; i++) begin
				ex(ops[j], (i < 16) ? {11'h000, 1'h1, 4'(i)} : 16'h0003);
				e[j] = (i < 16) ? (e[j] | (16'h0001 << i)) : 16'hFFF7;
				g = (j == 0) ? flag_bus : (j == 1) ? core_control : core_status;
				`CHK(g, e[j]) // bits
			end
		end
		ex(mcfu_pkg::OP_RSTREG, 16'h0001);
		`CHK({flag_bus, core_control, core_status}, 48'hFFF7_0000_FFF7) // control
		ex(mcfu_pkg::OP_RSTREG, 16'h0002);
		`CHK(core_status, 16'h0000) // status
		ex(mcfu_pkg::OP_RSTSL, 16'h0000);
		`CHK(start_latch_clr, 1'h1) // pulse
		cyc(1);
		`CHK(start_latch_clr, 1'h0) // one cycle
		ex(mcfu_pkg::OP_STAL, 16'h0010);
		ex(mcfu_pkg::OP_PIN_DRIVE, 16'h0010);
		`CHK({alu_saturate, host_interrupt_pin}, 2'h3) // set
		ex(mcfu_pkg::OP_STAL, 16'h0000);
		ex(mcfu_pkg::OP_PIN_DRIVE, 16'h0000);
		`CHK({alu_saturate, host_interrupt_pin}, 2'h0) // clear
	endtask
	// address base and read shaping
	task automatic t_ram();
		@(posedge sys_clk);
		ram_offset <= 10'h005;
		alu_index <= 16'h0020;
		ram_rdata <= 16'h12AB;
		ram_rd_en <= 1'h1;
		ex(mcfu_pkg::OP_STAB, 16'h0100);
		cyc(1);
		`CHK({ram_addr, ram_rd_value}, {10'h105, 16'h12AB}) // base load
		ex(mcfu_pkg::OP_SLAB, 16'h0010);
		cyc(1);
		`CHK(ram_addr, 10'h025) // index base
		ex(mcfu_pkg::OP_STDRM, 16'h0002);
		cyc(1);
		`CHK(ram_rd_value, 16'hAB12) // swap
		ex(mcfu_pkg::OP_STDRM, 16'h0001);
		cyc(1);
		`CHK(ram_rd_value, 16'h0000) // mask
	endtask
	// own exchange and peer selection
	task automatic t_xchg();
		@(posedge sys_clk);
		peer_exchange <= {16'hD3D3, 16'hC2C2, 16'hB1B1, 16'hA0A0};
		ex(mcfu_pkg::OP_LDRX, 16'h5A5A);
		`CHK(channel_exchange_register, 16'h5A5A) // own
		for (int k = 0; k < 4; k++) begin
			ex(mcfu_pkg::OP_STCRT, 16'(k));
			cyc(1);
			`CHK(peer_read_value, 16'hA0A0 + 16'(k) * 16'h1111) // peer
		end
	endtask
	// backdoor write, read and locked target
	task automatic t_bdoor();
		ex(mcfu_pkg::OP_SLSA, 16'h0040);
		ex(mcfu_pkg::OP_LDSD, 16'hBEEF);
		ex(mcfu_pkg::OP_WRSPI, 16'h0000);
		`CHK({bd_addr, bd_wr, instr_ready}, {9'h040, 2'h2}) // write
		cyc(1);
		`CHK({bd_wr, instr_ready}, 2'h1) // two cycles
		ex(mcfu_pkg::OP_LDSD, 16'h0000);
		ex(mcfu_pkg::OP_RDSPI, 16'h0000);
		`CHK(bd_rd, 1'h1) // read
		cyc(1);
		`CHK(bd_data, 16'hBEEF) // read data
		ex(mcfu_pkg::OP_SLSA, 16'h00FF);
		ex(mcfu_pkg::OP_LDSD, 16'h1234);
		ex(mcfu_pkg::OP_WRSPI, 16'h0000);
		`CHK(bd_wr, 1'h0) // locked write
		ex(mcfu_pkg::OP_RDSPI, 16'h0000);
		`CHK(bd_rd, 1'h0) // locked read
		cyc(1);
		`CHK(bd_data, 16'h1234) // data kept
	endtask
	// one subroutine level
	task automatic t_sub();
		p0 = pc_exp;
		`CHK(program_counter, p0) // steps
		ex(mcfu_pkg::OP_CALL, 16'h0200);
		`CHK(program_counter, 10'h200) // call
		ex(mcfu_pkg::OP_CALL, 16'h0300);
		`CHK(program_counter, 10'h201) // no nesting
		ex(mcfu_pkg::OP_RFS, 16'h0000);
		`CHK(program_counter, p0 + 10'h001) // return
		pc_exp = p0 + 10'h001;
	endtask
	// software interrupt, queue and clear
	task automatic t_irq();
		ex(mcfu_pkg::OP_REQI, 16'h0000);
		p0 = pc_exp;
		`CHK({in_irq, program_counter}, {1'h1, 10'h3A0}) // entry
		ex(mcfu_pkg::OP_REQI, 16'h0000);
		ex(mcfu_pkg::OP_IRET, 16'h0000);
		`CHK({in_irq, program_counter}, {1'h0, p0}) // saved pc
		cyc(1);
		`CHK({in_irq, program_counter}, {1'h1, 10'h3A0}) // queued
		ex(mcfu_pkg::OP_REQI, 16'h0000);
		ex(mcfu_pkg::OP_IRET, 16'h0002);
		cyc(2);
		`CHK({in_irq, program_counter}, {1'h0, p0}) // queue cleared
		pc_exp = p0;
	endtask
	// automatic return in all three modes
	task automatic t_auto();
		ex(mcfu_pkg::OP_ICONF, 16'h0000);
		ex(mcfu_pkg::OP_SLSA, 16'h01CE);
		ex(mcfu_pkg::OP_LDSD, 16'h0001);
		ex(mcfu_pkg::OP_WRSPI, 16'h0000);
		ex(mcfu_pkg::OP_SLSA, 16'h01D2);
		p0 = pc_exp;
		@(posedge sys_clk);
		driver_configuration <= 16'h0001;
		fault_in <= 16'h0004;
		@(posedge sys_clk);
		fault_in <= 16'h0000;
		cyc(3);
		`CHK({in_irq, program_counter}, {1'h1, 10'h3A0}) // driver entry
		ex(mcfu_pkg::OP_RDSPI, 16'h0000);
		cyc(3);
		`CHK({bd_data, in_irq, program_counter}, {16'h0004, 1'h0, p0}) // resume
		ex(mcfu_pkg::OP_ICONF, 16'h0001);
		@(posedge sys_clk);
		driver_configuration <= 16'h0000;
		drivers_enabled <= 1'h0;
		fault_in <= 16'h0004;
		@(posedge sys_clk);
		fault_in <= 16'h0000;
		cyc(3);
		`CHK(in_irq, 1'h1) // driver entry
		@(posedge sys_clk);
		drivers_enabled <= 1'h1;
		cyc(3);
		`CHK({in_irq, program_counter}, {1'h0, 10'h080}) // restart
		pc_exp = 10'h080;
		ex(mcfu_pkg::OP_RDSPI, 16'h0000);
		ex(mcfu_pkg::OP_ICONF, 16'h0003);
		ex(mcfu_pkg::OP_REQI, 16'h0000);
		p0 = pc_exp;
		@(posedge sys_clk);
		drivers_enabled <= 1'h0;
		@(posedge sys_clk);
		drivers_enabled <= 1'h1;
		cyc(3);
		`CHK(in_irq, 1'h1) // ignore mode
		ex(mcfu_pkg::OP_IRET, 16'h0000);
		`CHK({in_irq, program_counter}, {1'h0, p0}) // explicit return
		pc_exp = p0;
	endtask
	// diagnosis gating, routine address and priority
	task automatic t_diag();
		@(posedge sys_clk);
		highside_diagnosis_combination <= 16'h003C;
		lowside_diagnosis_combination <= 16'h000E;
		ex(mcfu_pkg::OP_ENDIAG, 16'h0012);
		@(posedge sys_clk);
		hs_vds_fbk <= 5'h04;
		cyc(4);
		`CHK({in_irq, diagnosis_error}, 17'h0) // not granted
		ex(mcfu_pkg::OP_REQI, 16'h0000);
		p0 = pc_exp;
		@(posedge sys_clk);
		output_access_grant <= 16'h0004;
		fault_in <= 16'h0004;
		@(posedge sys_clk);
		fault_in <= 16'h0000;
		ex(mcfu_pkg::OP_ENDIAG, 16'h0012);
		cyc(3);
		@(posedge sys_clk);
		hs_vds_fbk <= 5'h00;
		cyc(2);
		ex(mcfu_pkg::OP_IRET, 16'h0000);
		cyc(1);
		`CHK({in_irq, program_counter}, {1'h1, 10'h2C0}) // diagnosis first
		`CHK(|diagnosis_error, 1'h1) // error raised
		ex(mcfu_pkg::OP_RSTREG, 16'h0004);
		`CHK(diagnosis_error, 16'h0000) // errors
		ex(mcfu_pkg::OP_IRET, 16'h0000);
		cyc(1);
		`CHK({in_irq, program_counter}, {1'h1, 10'h3A0}) // driver next
		ex(mcfu_pkg::OP_IRET, 16'h0002);
		cyc(2);
		`CHK({in_irq, program_counter}, {1'h0, p0}) // back to main
		// all monitors off, then the shortcut set configured before use
		ex(mcfu_pkg::OP_ENDIAGA, 16'h0000);
		@(posedge sys_clk);
		hs_vds_fbk <= 5'h04;
		cyc(3);
		`CHK({in_irq, diagnosis_error}, 17'h0) // all off
		ex(mcfu_pkg::OP_DFSCT, 16'h0004);
		ex(mcfu_pkg::OP_ENDIAGS, 16'h0010);
		cyc(2);
		`CHK({in_irq, program_counter}, {1'h1, 10'h2C0}) // shortcut entry
		`CHK(diagnosis_error, 16'h0004) // shortcut error
		ex(mcfu_pkg::OP_ENDIAGS, 16'h0000);
		@(posedge sys_clk);
		hs_vds_fbk <= 5'h00;
		ex(mcfu_pkg::OP_RSTREG, 16'h0007);
		ex(mcfu_pkg::OP_IRET, 16'h0002);
		cyc(2);
		`CHK({in_irq, diagnosis_error}, 17'h0) // group clear
	endtask
	// main sequence
	initial begin
		{sys_clk, nrst, instr_valid, ram_rd_en, instr_op, instr_arg, alu_index, ram_rdata} = '0;
		{hs_vds_fbk, hs_src_fbk, hs_cmd, ls_vds_fbk, ls_cmd, output_access_grant} = '0;
		{fault_in, highside_diagnosis_combination, lowside_diagnosis_combination} = '0;
		{driver_configuration, ram_offset, peer_exchange, pc_exp, p0} = '0;
		{err_total, comparisons, cycles} = '0;
		drivers_enabled = 1'h1;
		diagnosis_routine_address = 10'h2C0;
		core_entry_point = 10'h080;
		irq_vector = 10'h3A0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'h1;
		cyc(1);
		t_bits();
		t_ram();
		t_xchg();
		t_bdoor();
		t_sub();
		t_irq();
		t_auto();
		t_diag();
		stop_test();
	end
endmodule
